// ==== shared/wdt_regs.svh ====
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// byte offsets on the register bus
`define WDT_ADDR_W     8
`define WDT_CTRL       8'h00
`define WDT_TIMEOUT    8'h04
`define WDT_PRESCALE   8'h08
`define WDT_RESTART    8'h0c
`define WDT_COUNT      8'h10
`define WDT_PCOUNT     8'h14
`define WDT_INT_STATUS 8'h18
`define WDT_INT_ENABLE 8'h1c
`define WDT_INT_CLEAR  8'h20
`define WDT_RST_SOURCE 8'h24

// control register fields; key value is arbitrary
`define WDT_KEY        16'ha5c3
`define WDT_KEY_HI     31
`define WDT_KEY_LO     16
`define WDT_CTRL_W     3
`define WDT_CTRL_EN    0
`define WDT_CTRL_PAUSE 1
`define WDT_CTRL_DEBUG 2
`define WDT_CTRL_RST   3'h0

// counter reset values
`define WDT_TIMEOUT_RST  32'hffff_ffff
`define WDT_PRESCALE_RST 32'h0000_0000

// interrupt status, enable and reset-source bits
`define WDT_INT_W      2
`define WDT_INT_OVF    0
`define WDT_INT_KEY    1
`define WDT_RSRC_WDT   0

`endif

// ==== shared/wdt_pkg.sv ====
`default_nettype none
`include "wdt_regs.svh"

package wdt_pkg;

	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

	typedef struct packed
	{
		logic [31:0] count;
		logic [31:0] pcount;
		logic        expire;
	} core_state_t;

	typedef struct packed
	{
		bus_state_t             bus;
		logic                   pready;
		logic                   pslverr;
		logic [31:0]            prdata;
		logic [`WDT_CTRL_W-1:0] ctrl;
		logic [31:0]            timeout;
		logic [31:0]            prescale;
		logic                   restart;
		logic [`WDT_INT_W-1:0]  int_status;
		logic [`WDT_INT_W-1:0]  int_enable;
		logic                   irq;
		logic                   reset_request;
		logic                   reset_source;
		logic                   dbg_s1;
		logic                   dbg_s2;
		logic                   dbg_s3;
		logic                   debug;
	} wdt_state_t;

endpackage
`default_nettype wire

// ==== src/wdt_count_core.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_count_core
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic        reload,
	input  wire logic [31:0] prescale,
	input  wire logic [31:0] timeout,
	output var  logic [31:0] count,
	output var  logic [31:0] pcount,
	output var  logic        expire
);
	import wdt_pkg::*;

	core_state_t s;
	core_state_t next_s;

	// down counters: period is (prescale+1)*(timeout+1) cycles
	always_comb
	begin
		next_s = s;
		next_s.expire = 1'b0;
		if (reload)
		begin
			next_s.pcount = prescale;
			next_s.count = timeout;
		end
		else if (run)
		begin
			if (s.pcount != 32'h0000_0000)
			begin
				next_s.pcount = s.pcount - 32'h0000_0001;
			end
			else
			begin
				next_s.pcount = prescale;
				if (s.count != 32'h0000_0000)
				begin
					next_s.count = s.count - 32'h0000_0001;
				end
				else
				begin
					// reload so debug mode keeps counting periods
					next_s.count = timeout;
					next_s.expire = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.count <= `WDT_TIMEOUT_RST;
			s.pcount <= `WDT_PRESCALE_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign count = s.count;
	assign pcount = s.pcount;
	assign expire = s.expire;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_RELOAD: assert property (reload |=> (s.count == $past(timeout))
		&& (s.pcount == $past(prescale)))
		else $error("counters not reloaded");
	AST_STALL: assert property (!run && !reload |=> $stable(s.count)
		&& $stable(s.pcount) && !s.expire)
		else $error("counters moved while stalled");
	AST_TICK: assert property (run && !reload
		&& s.pcount != 32'h0000_0000
		|=> s.pcount == $past(s.pcount) - 32'h0000_0001)
		else $error("prescaler did not step");

endmodule
`default_nettype wire

// ==== src/watchdog_timer.sv ====
// Behaviour
// - 32-bit counter stepped by 32-bit prescaler; both reload values software-set.
// - counter expiry raises a reset request toward the reset generator unit.
// - in watchdog debug mode expiry produces no system reset.
// - in debug mode expiry interrupts only when the interrupt is enabled.
// - writing the interrupt-clear register clears a pending overflow interrupt.
// - prescaler and counter stall while processor debugs and pause bit set.
// - control register changes only with the correct key; otherwise unchanged.
// - a reset-source record shows software the watchdog requested a reset; rst clears it.
// - register interface runs on core_clk, the same clock as the counters.
// - counters run on core_clk as well; control reaches them only through registers.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"

module watchdog_timer
(
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [`WDT_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output var  logic [31:0]           prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	input  wire logic                  debug_halted,
	output var  logic                  reset_request,
	output var  logic                  irq
);
	import wdt_pkg::*;

	wdt_state_t            s;
	wdt_state_t            next_s;
	logic                  hit;
	logic [31:0]           rd_data;
	logic                  wr;
	logic                  key_ok;
	logic                  ctrl_ok;
	logic                  key_evt;
	logic                  ld_timeout;
	logic                  ld_prescale;
	logic                  ld_restart;
	logic                  ld_enable;
	logic                  ld_status;
	logic                  ld_clear;
	logic                  ld_source;
	logic                  ovf_evt;
	logic                  expire_reset;
	logic                  run;
	logic                  reload;
	logic [`WDT_INT_W-1:0] int_set;
	logic [`WDT_INT_W-1:0] int_clr;
	logic                  src_clr;
	logic [31:0]           core_count;
	logic [31:0]           core_pcount;
	logic                  core_expire;

	// a write lands at the edge where pready is seen high
	assign wr = (s.bus == BUS_ACK) && psel && penable && pwrite;
	assign key_ok = pwdata[`WDT_KEY_HI:`WDT_KEY_LO] == `WDT_KEY;

	always_comb
	begin
		hit = 1'b1;
		rd_data = 32'h0000_0000;
		if (paddr == `WDT_CTRL)
		begin
			rd_data[`WDT_CTRL_W-1:0] = s.ctrl;
		end
		else if (paddr == `WDT_TIMEOUT)
		begin
			rd_data = s.timeout;
		end
		else if (paddr == `WDT_PRESCALE)
		begin
			rd_data = s.prescale;
		end
		else if (paddr == `WDT_RESTART)
		begin
			rd_data = 32'h0000_0000;
		end
		else if (paddr == `WDT_COUNT)
		begin
			rd_data = core_count;
		end
		else if (paddr == `WDT_PCOUNT)
		begin
			rd_data = core_pcount;
		end
		else if (paddr == `WDT_INT_STATUS)
		begin
			rd_data[`WDT_INT_W-1:0] = s.int_status;
		end
		else if (paddr == `WDT_INT_ENABLE)
		begin
			rd_data[`WDT_INT_W-1:0] = s.int_enable;
		end
		else if (paddr == `WDT_INT_CLEAR)
		begin
			rd_data = 32'h0000_0000;
		end
		else if (paddr == `WDT_RST_SOURCE)
		begin
			rd_data[`WDT_RSRC_WDT] = s.reset_source;
		end
		else
		begin
			hit = 1'b0;
		end
	end

	always_comb
	begin
		ctrl_ok = 1'b0;
		key_evt = 1'b0;
		ld_timeout = 1'b0;
		ld_prescale = 1'b0;
		ld_restart = 1'b0;
		ld_enable = 1'b0;
		ld_status = 1'b0;
		ld_clear = 1'b0;
		ld_source = 1'b0;
		if (wr)
		begin
			if (paddr == `WDT_CTRL)
			begin
				ctrl_ok = key_ok;
				key_evt = !key_ok;
			end
			else if (paddr == `WDT_TIMEOUT)
			begin
				ld_timeout = 1'b1;
			end
			else if (paddr == `WDT_PRESCALE)
			begin
				ld_prescale = 1'b1;
			end
			else if (paddr == `WDT_RESTART)
			begin
				ld_restart = 1'b1;
			end
			else if (paddr == `WDT_INT_STATUS)
			begin
				ld_status = 1'b1;
			end
			else if (paddr == `WDT_INT_ENABLE)
			begin
				ld_enable = 1'b1;
			end
			else if (paddr == `WDT_INT_CLEAR)
			begin
				ld_clear = 1'b1;
			end
			else if (paddr == `WDT_RST_SOURCE)
			begin
				ld_source = 1'b1;
			end
		end
	end

	// debug mode turns expiry into an interrupt instead of a reset
	assign ovf_evt = core_expire && s.ctrl[`WDT_CTRL_DEBUG];
	assign expire_reset = core_expire && !s.ctrl[`WDT_CTRL_DEBUG];
	assign src_clr = ld_source && pwdata[`WDT_RSRC_WDT];

	always_comb
	begin
		int_set = '0;
		int_set[`WDT_INT_OVF] = ovf_evt;
		int_set[`WDT_INT_KEY] = key_evt;
		int_clr = '0;
		if (ld_status)
		begin
			int_clr = pwdata[`WDT_INT_W-1:0];
		end
		if (ld_clear)
		begin
			int_clr[`WDT_INT_OVF] = 1'b1;
		end
	end

	always_comb
	begin
		next_s = s;
		next_s.restart = 1'b0;
		// the debug level comes from the processor's own clock
		next_s.dbg_s1 = debug_halted;
		next_s.dbg_s2 = s.dbg_s1;
		next_s.dbg_s3 = s.dbg_s2;
		if (s.dbg_s2 == s.dbg_s3)
		begin
			next_s.debug = s.dbg_s3;
		end
		case (s.bus)
		BUS_IDLE:
		begin
			if (psel && penable)
			begin
				next_s.bus = BUS_ACK;
				next_s.pready = 1'b1;
				next_s.pslverr = !hit;
				next_s.prdata = rd_data;
			end
		end
		BUS_ACK:
		begin
			next_s.bus = BUS_IDLE;
			next_s.pready = 1'b0;
			next_s.pslverr = 1'b0;
		end
		default:
		begin
			next_s.bus = BUS_IDLE;
			next_s.pready = 1'b0;
			next_s.pslverr = 1'b0;
		end
		endcase
		if (ctrl_ok)
		begin
			next_s.ctrl = pwdata[`WDT_CTRL_W-1:0];
		end
		if (ld_timeout)
		begin
			next_s.timeout = pwdata;
		end
		if (ld_prescale)
		begin
			next_s.prescale = pwdata;
		end
		if (ld_restart)
		begin
			next_s.restart = 1'b1;
		end
		if (ld_enable)
		begin
			next_s.int_enable = pwdata[`WDT_INT_W-1:0];
		end
		// a new event wins over a clear in the same cycle
		next_s.int_status = (s.int_status & ~int_clr) | int_set;
		next_s.reset_source = (s.reset_source && !src_clr)
			|| expire_reset;
		if (expire_reset)
		begin
			next_s.reset_request = 1'b1;
		end
		next_s.irq = |(next_s.int_status & next_s.int_enable);
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.bus <= BUS_IDLE;
			s.ctrl <= `WDT_CTRL_RST;
			s.timeout <= `WDT_TIMEOUT_RST;
			s.prescale <= `WDT_PRESCALE_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	// counters see only registered control, never raw bus terms
	assign run = s.ctrl[`WDT_CTRL_EN] && !s.reset_request
		&& !(s.ctrl[`WDT_CTRL_PAUSE] && s.debug);
	// disabled counters track the programmed values
	assign reload = s.restart || !s.ctrl[`WDT_CTRL_EN];

	wdt_count_core u_count
	(
		.core_clk (core_clk),
		.rst      (rst),
		.run      (run),
		.reload   (reload),
		.prescale (s.prescale),
		.timeout  (s.timeout),
		.count    (core_count),
		.pcount   (core_pcount),
		.expire   (core_expire)
	);

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign reset_request = s.reset_request;
	assign irq = s.irq;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_KEY_REJECT: assert property (wr && paddr == `WDT_CTRL
		&& !key_ok |=> $stable(s.ctrl) && s.int_status[`WDT_INT_KEY])
		else $error("control changed without key");
	AST_KEY_ACCEPT: assert property (wr && paddr == `WDT_CTRL
		&& key_ok |=> s.ctrl == $past(pwdata[`WDT_CTRL_W-1:0]))
		else $error("keyed control write lost");
	AST_RESET_REQ: assert property (core_expire
		&& !s.ctrl[`WDT_CTRL_DEBUG] |=> s.reset_request
		&& s.reset_source ##1 s.reset_request)
		else $error("expiry without reset request");
	AST_DEBUG_NO_RESET: assert property (core_expire
		&& s.ctrl[`WDT_CTRL_DEBUG] && !s.reset_request
		|=> !s.reset_request)
		else $error("reset raised in debug mode");
	AST_IRQ_ENABLED: assert property (ovf_evt
		&& s.int_enable[`WDT_INT_OVF] && !ld_enable |=> s.irq)
		else $error("enabled overflow gave no irq");
	AST_IRQ_MASKED: assert property (s.int_enable == '0
		&& !ld_enable |=> !s.irq)
		else $error("irq with all sources disabled");
	AST_INT_CLEAR: assert property (ld_clear && !ovf_evt
		|=> !s.int_status[`WDT_INT_OVF])
		else $error("clear register did not clear");
	AST_PAUSE: assert property (s.debug
		&& s.ctrl[`WDT_CTRL_PAUSE] && s.ctrl[`WDT_CTRL_EN]
		&& !s.restart |=> $stable(core_count))
		else $error("counter moved during pause");
	AST_DBG_SYNC: assert property (debug_halted[*4]
		|=> s.debug)
		else $error("debug level not taken");
	AST_RESTART: assert property (ld_restart
		|=> ##1 core_count == $past(s.timeout, 2))
		else $error("restart did not reload");
	AST_APB_ACK: assert property (psel && penable
		&& s.bus == BUS_IDLE |=> s.pready ##1 !s.pready)
		else $error("bus answer not one cycle");

	COV_RESET: cover property (expire_reset ##1 s.reset_request);
	COV_DEBUG_IRQ: cover property (ovf_evt ##1 s.irq);
	COV_KEY_BAD: cover property (key_evt);
	COV_PAUSE: cover property (s.debug && s.ctrl[`WDT_CTRL_PAUSE]);

endmodule
`default_nettype wire

// ==== verif/reset_gen_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module reset_gen_model
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       halt_cmd,
	input  wire logic       reset_request,
	output var  logic       debug_halted,
	output var  logic [7:0] resets
);
	logic seen;

	// processor debug state, changed only after a clock edge
	always_ff @(posedge core_clk)
	begin
		debug_halted <= halt_cmd;
		seen <= reset_request;
		if (rst)
			resets <= 8'h00;
		else if (reset_request && !seen)
			resets <= resets + 8'h01;
	end
endmodule

`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"

module tb_top;
	logic        core_clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        halt_cmd;
	logic        debug_halted;
	logic        reset_request;
	logic        irq;
	logic [7:0]  resets;
	logic [33:0] q[$];
	logic [33:0] note;
	logic [31:0] seed;
	logic [31:0] a;
	logic [31:0] b;
	int          err_total;
	int          checked;

	watchdog_timer watchdog_timer_inst
	(
		.core_clk     (core_clk),
		.rst          (rst),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.debug_halted (debug_halted),
		.reset_request(reset_request),
		.irq          (irq)
	);

	reset_gen_model reset_gen_model_inst
	(
		.core_clk     (core_clk),
		.rst          (rst),
		.halt_cmd     (halt_cmd),
		.reset_request(reset_request),
		.debug_halted (debug_halted),
		.resets       (resets)
	);

	initial
	begin
		core_clk = 1'b0;
		forever
			#5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer; the note goes to the watcher first
	task automatic xfer(input logic w, input logic [7:0] ad,
		input logic [31:0] d, input logic [33:0] nt,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		q.push_back(nt);
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'h1, {31'h0, n < 20});
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, ad, d, 34'h0, r);
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, ad, 32'h0, {2'b10, e}, r);
	endtask

	task automatic wait_for(input int sel, input int lim);
		int n;
		n = 0;
		while ((sel == 0 ? irq : reset_request) !== 1'b1 && n < lim)
		begin
			@(posedge core_clk);
			n++;
		end
		chk("wait", 32'h1, {31'h0, n < lim});
	endtask

	task automatic complete_run;
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// values sampled at the edge that carries pready
	always @(posedge core_clk)
		if (pready === 1'b1)
		begin
			note = q.pop_front();
			chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
			if (note[33])
				chk("prdata", note[31:0], prdata);
		end

	initial
	begin
		#200000;
		err_total++;
		complete_run();
	end

	initial
	begin
		err_total = 0;
		checked = 0;
		seed = 32'ha5cb7462;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		halt_cmd = 1'b0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(`WDT_CTRL, 32'h0);
		rd(`WDT_TIMEOUT, `WDT_TIMEOUT_RST);
		rd(`WDT_PRESCALE, `WDT_PRESCALE_RST);
		rd(`WDT_RST_SOURCE, 32'h0);
		xfer(1'b0, 8'h40, 32'h0, {2'b11, 32'h0}, a);
		wr(`WDT_COUNT, 32'h5);
		// disabled counters sit at the programmed values
		rd(`WDT_COUNT, `WDT_TIMEOUT_RST);
		rd(`WDT_PCOUNT, `WDT_PRESCALE_RST);
		repeat (2)
		begin
			seed = xs(seed);
			wr(`WDT_PRESCALE, seed);
			rd(`WDT_PRESCALE, seed);
			wr(`WDT_TIMEOUT, ~seed);
			rd(`WDT_TIMEOUT, ~seed);
		end
		$display("test registers done");
		wr(`WDT_CTRL, 32'h7);
		rd(`WDT_CTRL, 32'h0);
		rd(`WDT_INT_STATUS, 32'h2);
		wr(`WDT_INT_STATUS, 32'h2);
		rd(`WDT_INT_STATUS, 32'h0);
		$display("test key done");
		wr(`WDT_TIMEOUT, 32'h3);
		wr(`WDT_PRESCALE, 32'h1);
		wr(`WDT_CTRL, {`WDT_KEY, 16'h0005});
		wr(`WDT_RESTART, 32'h0);
		rd(`WDT_CTRL, 32'h5);
		repeat (40) @(posedge core_clk);
		chk("irq", 32'h0, {31'h0, irq});
		chk("reset_request", 32'h0, {31'h0, reset_request});
		rd(`WDT_INT_STATUS, 32'h1);
		// stop counting so no new overflow races the clear
		wr(`WDT_CTRL, {`WDT_KEY, 16'h0004});
		wr(`WDT_INT_ENABLE, 32'h1);
		wait_for(0, 4);
		wr(`WDT_INT_CLEAR, 32'h0);
		repeat (2) @(posedge core_clk);
		#1 chk("irq", 32'h0, {31'h0, irq});
		rd(`WDT_INT_STATUS, 32'h0);
		$display("test interrupt done");
		wr(`WDT_PRESCALE, 32'h0);
		wr(`WDT_TIMEOUT, 32'd1000);
		wr(`WDT_CTRL, {`WDT_KEY, 16'h0007});
		wr(`WDT_RESTART, 32'h0);
		halt_cmd <= 1'b1;
		repeat (10) @(posedge core_clk);
		xfer(1'b0, `WDT_COUNT, 32'h0, 34'h0, a);
		repeat (5) @(posedge core_clk);
		xfer(1'b0, `WDT_COUNT, 32'h0, 34'h0, b);
		chk("stalled", a, b);
		halt_cmd <= 1'b0;
		repeat (10) @(posedge core_clk);
		xfer(1'b0, `WDT_COUNT, 32'h0, 34'h0, b);
		chk("running", 32'h1, {31'h0, a != b});
		$display("test pause done");
		wr(`WDT_PRESCALE, 32'd100);
		wr(`WDT_CTRL, {`WDT_KEY, 16'h0005});
		repeat (300) @(posedge core_clk);
		wr(`WDT_RESTART, 32'h0);
		rd(`WDT_COUNT, 32'd1000);
		$display("test restart done");
		wr(`WDT_PRESCALE, 32'h0);
		wr(`WDT_TIMEOUT, 32'h2);
		wr(`WDT_RESTART, 32'h0);
		wr(`WDT_CTRL, {`WDT_KEY, 16'h0001});
		wait_for(1, 40);
		rd(`WDT_RST_SOURCE, 32'h1);
		chk("resets", 32'h1, {24'h0, resets});
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		#1 chk("reset_request", 32'h0, {31'h0, reset_request});
		rd(`WDT_RST_SOURCE, 32'h0);
		$display("test expiry done");
		complete_run();
	end
endmodule

`default_nettype wire
